// *** scr_config_regs.sv ***
// Purpose: system configuration and physical layer control registers
// Assumes: serial pins and wake pin are asynchronous; mode events are same-clock pulses
// Notes:   other frame addresses are ignored and answer with zero
`timescale 1ns/1ps
`include "scr_defines.svh"
module scr_config_regs #(
  parameter int unsigned RST_SHORT_CYC = `SCR_RST_SHORT_CYC,
  parameter int unsigned RST_LONG_CYC  = `SCR_RST_LONG_CYC
) (
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  // serial port pins
  input  wire logic              spi_sck_in,
  input  wire logic              spi_csn_in,
  input  wire logic              spi_mosi_in,
  output logic                   spi_miso_out,
  // general purpose feedback contents
  input  wire scr_pkg::scr_word_t gp_fb0_in,
  input  wire scr_pkg::scr_word_t gp_fb1_in,
  // mode events from the mode logic
  input  wire logic              enter_restart_in,
  input  wire logic              enter_failsafe_in,
  input  wire logic              enter_online_in,
  input  wire logic              enter_active_in,
  input  wire logic              can_online_req_in,
  input  wire logic              can_offline_in,
  input  wire logic              wake_seen_in,
  input  wire logic              standby_wd_off_in,
  input  wire logic              supply_cur_rise_in,
  input  wire logic              iface_fail_in,
  input  wire logic              iface_recover_in,
  // wake pin and status
  input  wire logic              wake_pin_in,
  output logic                   wake_event_status_out,
  output logic                   wake_level_status_out,
  output logic                   wake_sampling_select_out,
  // inhibit pin
  output logic                   inhibit_fallback_output_out,
  output logic                   inhibit_fallback_oe_out,
  // reset pin
  input  wire logic              ext_rst_n_in,
  output logic                   rst_pin_n_out,
  output logic                   rst_pin_oe_out,
  // supply and watchdog effects
  output logic                   supply_rst_req_out,
  output logic                   wd_reactivate_out,
  output logic                   bus_supply_regulator_on_out,
  // can transceiver control
  input  wire logic              can_txd_in,
  output logic                   can_tx_en_out,
  output logic                   can_rxd_loop_out,
  output logic                   can_loop_active_out,
  output logic                   can_listen_out,
  output logic                   can_online_out,
  output logic                   offline_long_out,
  output logic                   offline_ext_out
);
  import scr_pkg::*;

  logic            rst_s1_r;
  logic            rst_s2_r;
  logic            sck_s1_r, sck_s2_r;
  logic            csn_s1_r, csn_s2_r;
  logic            mosi_s1_r, mosi_s2_r;
  logic            wake_s1_r, wake_s2_r;
  logic            xrst_s1_r, xrst_s2_r, xrst_d_r;
  logic [11:0]     sys_r;
  logic [11:0]     phy_r;
  logic            tx_fault_r;
  logic            woke_r;
  logic            wake_d_r;
  scr_word_t       answer;
  scr_word_t       frame;
  logic            frame_done;
  logic            stretch_req;
  logic            stretch_active;

  // reset release through two stages
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // pin synchronisers
  always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      csn_s1_r  <= 1'b1;
      csn_s2_r  <= 1'b1;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      wake_s1_r <= 1'b1;
      wake_s2_r <= 1'b1;
      xrst_s1_r <= 1'b1;
      xrst_s2_r <= 1'b1;
    end else begin
      sck_s1_r  <= spi_sck_in;
      sck_s2_r  <= sck_s1_r;
      csn_s1_r  <= spi_csn_in;
      csn_s2_r  <= csn_s1_r;
      mosi_s1_r <= spi_mosi_in;
      mosi_s2_r <= mosi_s1_r;
      wake_s1_r <= wake_pin_in;
      wake_s2_r <= wake_s1_r;
      xrst_s1_r <= ext_rst_n_in;
      xrst_s2_r <= xrst_s1_r;
    end
  end

  function automatic scr_word_t fb_pick(input logic rd_sel, input scr_word_t gp, input scr_word_t own);
    fb_pick = rd_sel ? gp : own;
  endfunction

  // answer chosen at frame start from the sampled frame bits is impossible, so the
  // previous frame's address and select decide the answer of the next frame
  logic [1:0] last_addr_r;
  logic       last_sel_r;

  always_comb begin
    case (last_addr_r)
      `SCR_ADDR_SYSCFG: answer = fb_pick(last_sel_r, gp_fb0_in, {`SCR_ADDR_SYSCFG, 2'h0, sys_r});
      `SCR_ADDR_PHYCTL: answer = fb_pick(last_sel_r, gp_fb1_in, {`SCR_ADDR_PHYCTL, 2'h0, phy_r});
      default:          answer = 16'h0000;
    endcase
  end

  scr_spi_shift u_shift (
    .clk_in    (sys_clk_in),
    .rst_n_in  (rst_s2_r),
    .sck_in    (sck_s2_r),
    .csn_in    (csn_s2_r),
    .mosi_in   (mosi_s2_r),
    .miso_out  (spi_miso_out),
    .answer_in (answer),
    .start_out (),
    .done_out  (frame_done),
    .word_out  (frame)
  );

  always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      last_addr_r <= 2'h0;
      last_sel_r  <= 1'b0;
    end else if (frame_done) begin
      last_addr_r <= frame[`SCR_ADDR_HI:`SCR_ADDR_LO];
      last_sel_r  <= frame[`SCR_RD_SEL_BIT];
    end
  end

  // system configuration register
  always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      sys_r <= `SCR_SYS_RESET;
    end else begin
      if (frame_done && frame[`SCR_ADDR_HI:`SCR_ADDR_LO] == `SCR_ADDR_SYSCFG
          && !frame[`SCR_RO_BIT]) begin
        // reserved bit is not stored, host keeps it zero
        sys_r <= frame[11:0] & `SCR_SYS_WMASK;
      end
      // automatic set wins over a same-cycle write
      if (enter_restart_in || enter_failsafe_in)
        sys_r[`SCR_SYS_RLC_BIT] <= 1'b1;
    end
  end

  // physical layer control register
  always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      phy_r <= `SCR_PHY_RESET;
    end else begin
      if (frame_done && frame[`SCR_ADDR_HI:`SCR_ADDR_LO] == `SCR_ADDR_PHYCTL
          && !frame[`SCR_RO_BIT])
        phy_r <= frame[11:0] & `SCR_PHY_WMASK;
      if (enter_online_in || enter_active_in)
        phy_r[`SCR_PHY_PN_BIT] <= 1'b0;
    end
  end

  // interface failure latch, kept out of the transmitter bit
  always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
    if (!rst_s2_r)
      tx_fault_r <= 1'b0;
    else if (iface_fail_in)
      tx_fault_r <= 1'b1;
    else if (iface_recover_in || phy_r[`SCR_PHY_TXDIS_BIT])
      tx_fault_r <= 1'b0;
  end

  // wake-up memory for the extended off-line timeout
  always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
    if (!rst_s2_r)
      woke_r <= 1'b0;
    else if (wake_seen_in)
      woke_r <= 1'b1;
    else if (can_offline_in)
      woke_r <= 1'b0;
  end

  // wake port status
  // edge tracker follows the pin even while disabled, so enabling never reports a stale edge
  always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      wake_d_r              <= 1'b1;
      wake_event_status_out <= 1'b0;
      wake_level_status_out <= 1'b0;
    end else begin
      wake_d_r <= wake_s2_r;
      if (sys_r[`SCR_SYS_WEN_BIT]) begin
        wake_level_status_out <= wake_s2_r;
        if (wake_d_r && !wake_s2_r)
          wake_event_status_out <= 1'b1;
      end
    end
  end

  // reset stretching
  always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
    if (!rst_s2_r)
      xrst_d_r <= 1'b1;
    else
      xrst_d_r <= xrst_s2_r;
  end

  assign stretch_req = (xrst_d_r && !xrst_s2_r)
                       || (sys_r[`SCR_SYS_CURPOL_BIT] && standby_wd_off_in && supply_cur_rise_in);

  scr_rst_stretch #(
    .SHORT_CYC (RST_SHORT_CYC),
    .LONG_CYC  (RST_LONG_CYC)
  ) u_stretch (
    .clk_in         (sys_clk_in),
    .rst_n_in       (rst_s2_r),
    .req_in         (stretch_req),
    .long_in        (sys_r[`SCR_SYS_RLC_BIT]),
    .rst_active_out (stretch_active)
  );

  // registered outputs
  always_ff @(posedge sys_clk_in or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      wake_sampling_select_out    <= 1'b0;
      inhibit_fallback_output_out <= 1'b0;
      inhibit_fallback_oe_out     <= 1'b0;
      rst_pin_n_out               <= 1'b0;
      rst_pin_oe_out              <= 1'b1;
      supply_rst_req_out          <= 1'b0;
      wd_reactivate_out           <= 1'b0;
      bus_supply_regulator_on_out <= 1'b0;
      can_tx_en_out               <= 1'b0;
      can_rxd_loop_out            <= 1'b1;
      can_loop_active_out         <= 1'b0;
      can_listen_out              <= 1'b0;
      can_online_out              <= 1'b0;
      offline_long_out            <= 1'b0;
      offline_ext_out             <= 1'b0;
    end else begin
      wake_sampling_select_out    <= sys_r[`SCR_SYS_WSAMP_BIT];
      inhibit_fallback_oe_out     <= sys_r[`SCR_SYS_INHEN_BIT];
      inhibit_fallback_output_out <= sys_r[`SCR_SYS_INHEN_BIT] & sys_r[`SCR_SYS_INHLVL_BIT];
      rst_pin_n_out               <= 1'b0;
      rst_pin_oe_out              <= stretch_active;
      supply_rst_req_out <= standby_wd_off_in && supply_cur_rise_in && sys_r[`SCR_SYS_CURPOL_BIT];
      wd_reactivate_out  <= standby_wd_off_in && supply_cur_rise_in && !sys_r[`SCR_SYS_CURPOL_BIT];
      bus_supply_regulator_on_out <= !can_offline_in || phy_r[`SCR_PHY_V2_BIT];
      can_tx_en_out    <= !phy_r[`SCR_PHY_TXDIS_BIT] && !tx_fault_r;
      can_loop_active_out <= phy_r[`SCR_PHY_LOOP_BIT] && phy_r[`SCR_PHY_TXDIS_BIT];
      can_rxd_loop_out <= can_txd_in;
      can_listen_out   <= can_online_req_in && phy_r[`SCR_PHY_PN_BIT];
      can_online_out   <= can_online_req_in && !phy_r[`SCR_PHY_PN_BIT];
      offline_long_out <= phy_r[`SCR_PHY_OTO_BIT];
      offline_ext_out  <= woke_r;
    end
  end
endmodule // scr_config_regs

// *** scr_defines.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the config registers
// Assumes: 16-bit serial frames, 20 MHz system clock
// Notes:   bit positions index the 16-bit frame and the stored register alike
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// frame fields
`define SCR_ADDR_HI          15
`define SCR_ADDR_LO          14
`define SCR_RD_SEL_BIT       13
`define SCR_RO_BIT           12
`define SCR_ADDR_SYSCFG      2'h2
`define SCR_ADDR_PHYCTL      2'h3

// system configuration fields
`define SCR_SYS_RLC_BIT      8
`define SCR_SYS_RSVD_BIT     5
`define SCR_SYS_CURPOL_BIT   4
`define SCR_SYS_WEN_BIT      3
`define SCR_SYS_WSAMP_BIT    2
`define SCR_SYS_INHEN_BIT    1
`define SCR_SYS_INHLVL_BIT   0
`define SCR_SYS_WMASK        12'h3DF
`define SCR_SYS_RESET        12'h000

// physical layer control fields
`define SCR_PHY_V2_BIT       11
`define SCR_PHY_PN_BIT       10
`define SCR_PHY_OTO_BIT      9
`define SCR_PHY_TXDIS_BIT    8
`define SCR_PHY_LOOP_BIT     7
`define SCR_PHY_WMASK        12'hF80
`define SCR_PHY_RESET        12'h000

// reset lengthening times
`define SCR_CLK_MHZ          20
`define SCR_RST_SHORT_US     1
`define SCR_RST_LONG_US      20
`define SCR_RST_SHORT_CYC    (`SCR_RST_SHORT_US * `SCR_CLK_MHZ)
`define SCR_RST_LONG_CYC     (`SCR_RST_LONG_US * `SCR_CLK_MHZ)

`endif

// *** scr_pkg.sv ***
// Purpose: shared types of the config register block
// Assumes: nothing beyond the defines header
// Notes:   types only
package scr_pkg;
  typedef enum logic [1:0] {SCR_FR_IDLE, SCR_FR_SHIFT, SCR_FR_DONE} scr_frame_state_t;
  typedef logic [15:0] scr_word_t;
endpackage

// *** scr_spi_shift.sv ***
// Purpose: 16-bit serial frame shifter, msb first, mode 0
// Assumes: serial pins already synchronised to sys_clk
// Notes:   returns the answer word loaded at frame start
`timescale 1ns/1ps
module scr_spi_shift (
  // clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  // synchronised pins
  input  wire logic            sck_in,
  input  wire logic            csn_in,
  input  wire logic            mosi_in,
  output logic                 miso_out,
  // frame side
  input  wire scr_pkg::scr_word_t answer_in,
  output logic                 start_out,
  output logic                 done_out,
  output scr_pkg::scr_word_t   word_out
);
  import scr_pkg::*;

  logic             sck_d_r;
  logic             csn_d_r;
  logic [4:0]       cnt_r;
  scr_word_t        rx_r;
  scr_word_t        tx_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_d_r <= 1'b0;
      csn_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_in;
      csn_d_r <= csn_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r     <= 5'h00;
      rx_r      <= 16'h0000;
      tx_r      <= 16'h0000;
      start_out <= 1'b0;
      done_out  <= 1'b0;
      word_out  <= 16'h0000;
    end else begin
      start_out <= 1'b0;
      done_out  <= 1'b0;
      if (csn_d_r && !csn_in) begin
        cnt_r     <= 5'h00;
        tx_r      <= answer_in;
        start_out <= 1'b1;
      end else if (!csn_in && sck_in && !sck_d_r) begin
        rx_r  <= {rx_r[14:0], mosi_in};
        cnt_r <= cnt_r + 5'h01;
      end else if (!csn_in && !sck_in && sck_d_r) begin
        tx_r <= {tx_r[14:0], 1'b0};
      end else if (!csn_d_r && csn_in) begin
        // frames whose bit count is not 16 modulo 32 are dropped, nothing is written
        if (cnt_r == 5'h10) begin
          done_out <= 1'b1;
          word_out <= rx_r;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      miso_out <= 1'b0;
    else
      miso_out <= tx_r[15];
  end
endmodule // scr_spi_shift

// *** scr_rst_stretch.sv ***
// Purpose: stretch reset pulses to the programmed length
// Assumes: request is synchronous to clk
// Notes:   counts restart on every new request
`timescale 1ns/1ps
module scr_rst_stretch #(
  parameter int unsigned SHORT_CYC = 20,
  parameter int unsigned LONG_CYC  = 400
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // control
  input  wire logic req_in,
  input  wire logic long_in,
  output logic      rst_active_out
);
  logic [15:0] cnt_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r          <= 16'h0000;
      rst_active_out <= 1'b0;
    end else begin
      if (req_in)
        cnt_r <= long_in ? 16'(LONG_CYC) : 16'(SHORT_CYC);
      else if (cnt_r != 16'h0000)
        cnt_r <= cnt_r - 16'h0001;
      rst_active_out <= req_in || (cnt_r > 16'h0001);
    end
  end
endmodule // scr_rst_stretch

// *** scr_config_regs_asserts.sv ***
// Purpose: port-level checks of the config register block
// Assumes: mode events are one-cycle pulses; stretch lengths come from parameters
// Notes:   oe_q_r starts high because the reset pin is driven during reset
`timescale 1ns/1ps
module scr_config_regs_asserts #(
  parameter int unsigned RST_SHORT_CYC = 20,
  parameter int unsigned RST_LONG_CYC  = 400
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // watched inputs
  input wire logic enter_online_in,
  input wire logic enter_active_in,
  input wire logic wake_seen_in,
  input wire logic standby_wd_off_in,
  input wire logic supply_cur_rise_in,
  input wire logic iface_fail_in,
  input wire logic iface_recover_in,
  input wire logic can_txd_in,
  // watched outputs
  input wire logic rst_pin_oe_out,
  input wire logic supply_rst_req_out,
  input wire logic wd_reactivate_out,
  input wire logic can_tx_en_out,
  input wire logic can_rxd_loop_out,
  input wire logic can_loop_active_out,
  input wire logic can_listen_out,
  input wire logic can_online_out,
  input wire logic offline_ext_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [9:0] oe_len_r;
  logic       oe_q_r;
  logic       seen_rise_r;
  // power-on stretch is ignored, only stretches that rise after reset count
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      oe_len_r    <= 10'h000;
      oe_q_r      <= 1'b1;
      seen_rise_r <= 1'b0;
    end else begin
      oe_len_r    <= rst_pin_oe_out ? oe_len_r + 10'h001 : 10'h000;
      oe_q_r      <= rst_pin_oe_out;
      seen_rise_r <= seen_rise_r | (rst_pin_oe_out & ~oe_q_r);
    end
  end
  sequence s_fault;
    iface_fail_in && !iface_recover_in ##1 !iface_recover_in;
  endsequence
  sequence s_stretch_end;
    seen_rise_r && oe_q_r && !rst_pin_oe_out;
  endsequence
  AST_LOOP_COPY: assert property (can_loop_active_out && $past(can_loop_active_out) |->
    can_rxd_loop_out == $past(can_txd_in)) else $error("loop output does not follow txd");
  AST_LOOP_TXOFF: assert property (can_loop_active_out |-> !can_tx_en_out)
    else $error("loopback with transmitter enabled");
  AST_LISTEN_EXCL: assert property (can_listen_out |-> !can_online_out)
    else $error("listen and on-line together");
  AST_PN_CLEAR: assert property ((enter_online_in || enter_active_in) |-> ##2 !can_listen_out)
    else $error("listen mode kept after mode entry");
  AST_FAULT_TXOFF: assert property (s_fault |-> ##1 !can_tx_en_out)
    else $error("transmitter left on after interface fault");
  AST_SUPPLY_RST: assert property (supply_rst_req_out |-> $past(supply_cur_rise_in) && $past(standby_wd_off_in))
    else $error("supply reset without cause");
  AST_WD_REACT: assert property (wd_reactivate_out |-> $past(supply_cur_rise_in) && !supply_rst_req_out)
    else $error("watchdog reactivation without cause");
  AST_EXT_TIMEOUT: assert property (wake_seen_in |-> ##[1:2] offline_ext_out)
    else $error("extended off-line time not taken after wake");
  AST_STRETCH_MIN: assert property (s_stretch_end |-> oe_len_r >= 10'(RST_SHORT_CYC))
    else $error("reset pulse shorter than short length");
  AST_STRETCH_MAX: assert property (seen_rise_r && rst_pin_oe_out |-> oe_len_r < 10'(RST_LONG_CYC + 8))
    else $error("reset pulse far beyond long length");
endmodule // scr_config_regs_asserts

bind scr_config_regs scr_config_regs_asserts #(
  .RST_SHORT_CYC(RST_SHORT_CYC),
  .RST_LONG_CYC (RST_LONG_CYC)
) chk_u (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .enter_online_in(enter_online_in),
  .enter_active_in(enter_active_in), .wake_seen_in(wake_seen_in), .standby_wd_off_in(standby_wd_off_in),
  .supply_cur_rise_in(supply_cur_rise_in), .iface_fail_in(iface_fail_in), .iface_recover_in(iface_recover_in),
  .can_txd_in(can_txd_in), .rst_pin_oe_out(rst_pin_oe_out), .supply_rst_req_out(supply_rst_req_out),
  .wd_reactivate_out(wd_reactivate_out), .can_tx_en_out(can_tx_en_out), .can_rxd_loop_out(can_rxd_loop_out),
  .can_loop_active_out(can_loop_active_out), .can_listen_out(can_listen_out), .can_online_out(can_online_out),
  .offline_ext_out(offline_ext_out)
);

// *** scr_host_model.sv ***
// Purpose: host serial master issuing 16-bit frames
// Assumes: mode 0, msb first
// Notes:   phase length per call, 2 clocks is the shortest legal phase
`timescale 1ns/1ps
module scr_host_model (
  // clock
  input  wire logic clk_in,
  // serial pins
  output logic      sck_out,
  output logic      csn_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  initial begin
    sck_out = 1'b0;
    csn_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, input int ph);
    @(posedge clk_in) #2 csn_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_out = (i == 5 && tx[15:14] == 2'b10) ? 1'b0 : tx[i];
      repeat (ph) @(posedge clk_in);
      #2 sck_out = 1'b1;
      repeat (ph) @(posedge clk_in);
      #2 rx[i] = miso_in;
      sck_out = 1'b0;
    end
    repeat (ph) @(posedge clk_in);
    #2 csn_out = 1'b1;
    // released data line must not hold a stale bit
    mosi_out = ~tx[0];
    repeat (8) @(posedge clk_in);
    #2;
  endtask
endmodule // scr_host_model

// *** tb_scr_config_regs.sv ***
// Purpose: directed bench for the config register block
// Assumes: host model makes frames; mode events are one-cycle pulses
// Notes:   stretch lengths cut to 4/8 cycles to keep the run short
`timescale 1ns/1ps
module tb_scr_config_regs;
  import scr_pkg::*;
  localparam int unsigned SHORT = 4;
  localparam int unsigned LONG  = 8;
  logic        ck = 1'b0;
  logic        rn, on_req, off, wdoff, wpin, xrst, txd;
  logic [7:0]  ev;
  logic        sck, csn, mosi, miso, wev, wlv, wss, inh, inh_oe, roe, srst, wdr, v2on, txen, rxl, loop, lis, onl;
  logic        olong, oext, rpn;
  scr_word_t   fb0 = 16'h5AC3;
  scr_word_t   fb1 = 16'hA53C;
  scr_word_t   ans;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n_srst = 0;
  int          n_wdr = 0;
  scr_host_model host_u (.clk_in(ck), .sck_out(sck), .csn_out(csn), .mosi_out(mosi), .miso_in(miso));
  scr_config_regs #(.RST_SHORT_CYC(SHORT), .RST_LONG_CYC(LONG)) dut_u (
    .sys_clk_in(ck), .resetn_in(rn), .spi_sck_in(sck), .spi_csn_in(csn), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .gp_fb0_in(fb0), .gp_fb1_in(fb1), .enter_restart_in(ev[0]), .enter_failsafe_in(ev[1]),
    .enter_online_in(ev[2]), .enter_active_in(ev[3]), .can_online_req_in(on_req), .can_offline_in(off),
    .wake_seen_in(ev[4]), .standby_wd_off_in(wdoff), .supply_cur_rise_in(ev[5]), .iface_fail_in(ev[6]),
    .iface_recover_in(ev[7]), .wake_pin_in(wpin), .wake_event_status_out(wev), .wake_level_status_out(wlv),
    .wake_sampling_select_out(wss), .inhibit_fallback_output_out(inh), .inhibit_fallback_oe_out(inh_oe),
    .ext_rst_n_in(xrst), .rst_pin_n_out(rpn), .rst_pin_oe_out(roe), .supply_rst_req_out(srst),
    .wd_reactivate_out(wdr), .bus_supply_regulator_on_out(v2on), .can_txd_in(txd), .can_tx_en_out(txen),
    .can_rxd_loop_out(rxl), .can_loop_active_out(loop), .can_listen_out(lis), .can_online_out(onl),
    .offline_long_out(olong), .offline_ext_out(oext));
  always #25 ck = ~ck;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ck) begin
    cyc++;
    if (srst === 1'b1) n_srst++;
    if (wdr === 1'b1) n_wdr++;
    // about 5300 cycles expected
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk_w(input scr_word_t got, input scr_word_t exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({15'h0, got}, {15'h0, exp});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ck);
    #2;
  endtask
  task automatic wr(input scr_word_t w);
    host_u.xfer(w, ans, 4);
  endtask
  // answers are pipelined one frame, so a read needs two frames
  task automatic rd(input scr_word_t w, input int ph, input scr_word_t exp);
    host_u.xfer(w, ans, ph);
    host_u.xfer(w, ans, ph);
    chk_w(ans, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge ck) #2 ev[k] = 1'b1;
    @(posedge ck) #2 ev[k] = 1'b0;
    step(4);
  endtask
  task automatic stretch(input int lo, input int hi);
    int n;
    n = 0;
    @(posedge ck) #2 xrst = 1'b0;
    @(posedge ck) #2 xrst = 1'b1;
    for (int i = 0; i < 10 && roe !== 1'b1; i++) step(1);
    chk_b(rpn, 1'b0);
    while (roe === 1'b1 && n < 60) begin
      step(1);
      n++;
    end
    chk_b(n >= lo && n <= hi, 1'b1);
  endtask
  initial begin
    {rn, on_req, off, wdoff, wpin, txd} = 6'h00;
    xrst = 1'b1;
    ev = 8'h00;
    step(12);
    rn = 1'b1;
    step(6);
    chk_b(txen, 1'b1);
    chk_b(inh_oe, 1'b0);
    wpin = 1'b1;
    step(6);
    wpin = 1'b0;
    step(6);
    chk_b(wev, 1'b0);
    chk_b(wlv, 1'b0);
    wr(16'h801B);
    chk_b(wss, 1'b0);
    chk_b(inh_oe, 1'b1);
    chk_b(inh, 1'b1);
    wpin = 1'b1;
    step(6);
    chk_b(wlv, 1'b1);
    chk_b(wev, 1'b0);
    wpin = 1'b0;
    step(6);
    chk_b(wev, 1'b1);
    wr(16'h8016);
    chk_b(wss, 1'b1);
    chk_b(inh, 1'b0);
    $display("test 1 wake and inhibit done");
    rd(16'h9FFF, 3, 16'h8016);
    rd(16'hB000, 6, fb0);
    for (int k = 0; k < 2; k++) rd({2'(k), 14'h0FFF}, 4, 16'h0000);
    rd(16'h9000, 4, 16'h8016);
    rd(16'hD000, 4, 16'hC000);
    $display("test 2 readback done");
    wdoff = 1'b1;
    pulse(5);
    chk_w(16'(n_srst), 16'h0001);
    wr(16'h8006);
    step(40);
    pulse(5);
    chk_w(16'(n_wdr), 16'h0001);
    chk_w(16'(n_srst), 16'h0001);
    $display("test 3 supply current done");
    for (int k = 0; k < 2; k++) begin
      wr(16'h8006);
      pulse(k);
      rd(16'h9000, 4, 16'h8106);
    end
    stretch(LONG, LONG + 3);
    wr(16'h8006);
    stretch(SHORT, SHORT + 3);
    $display("test 4 reset length done");
    off = 1'b1;
    wr(16'hCB80);
    chk_b(txen, 1'b0);
    chk_b(loop, 1'b1);
    chk_b(olong, 1'b1);
    chk_b(v2on, 1'b1);
    txd = 1'b1;
    step(3);
    chk_b(rxl, 1'b1);
    txd = 1'b0;
    step(3);
    chk_b(rxl, 1'b0);
    rd(16'hD000, 4, 16'hCB80);
    rd(16'hF000, 4, fb1);
    wr(16'hC080);
    chk_b(loop, 1'b0);
    chk_b(txen, 1'b1);
    chk_b(olong, 1'b0);
    chk_b(v2on, 1'b0);
    off = 1'b0;
    $display("test 5 transceiver control done");
    on_req = 1'b1;
    for (int k = 2; k < 4; k++) begin
      wr(16'hC400);
      chk_b(lis, 1'b1);
      chk_b(onl, 1'b0);
      pulse(k);
      chk_b(lis, 1'b0);
      chk_b(onl, 1'b1);
      rd(16'hD000, 4, 16'hC000);
    end
    pulse(4);
    chk_b(oext, 1'b1);
    pulse(6);
    chk_b(txen, 1'b0);
    rd(16'hD000, 4, 16'hC000);
    pulse(7);
    chk_b(txen, 1'b1);
    $display("test 6 listen, wake and fault done");
    give_verdict();
  end
endmodule // tb_scr_config_regs
